/* hw/ccr_pkg.sv */
// Constants shared by the charger configuration register bank
package ccr_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 8;

  // Register offsets
  localparam logic [7:0] OFS_TERM = 8'h03;
  localparam logic [7:0] OFS_CURR = 8'h04;
  localparam logic [7:0] OFS_THRS = 8'h05;
  localparam logic [7:0] OFS_TIMER = 8'h06;
  localparam logic [7:0] OFS_FUNC = 8'h07;

  // Reset values
  localparam logic [7:0] TERM_RST = 8'h02;
  localparam logic [7:0] CURR_RST = 8'h29;
  localparam logic [7:0] THRS_RST = 8'h2B;
  localparam logic [7:0] TIMER_RST = 8'h07;
  localparam logic [7:0] FUNC_RST = 8'h0C;

  // Writable bits and bits loaded from factory straps
  localparam logic [7:0] ALL_MASK = 8'hFF;
  localparam logic [7:0] NONE_MASK = 8'h00;
  localparam logic [7:0] TIMER_MASK = 8'h0F;
  localparam logic [7:0] TERM_STRAP_MASK = 8'hFC;
  localparam logic [7:0] FUNC_STRAP_MASK = 8'h01;

  // Field positions
  localparam int FLOAT_VOLTAGE_CODE_LSB = 2;
  localparam int TRK_LSB = 0;
  localparam int END_CURRENT_CODE_LSB = 5;
  localparam int FAST_CURRENT_CODE_LSB = 0;
  localparam int RCH_INH_BIT = 7;
  localparam int RECHARGE_OFFSET_CODE_LSB = 5;
  localparam int VDEAD_LSB = 3;
  localparam int WEAK_BATTERY_THRESHOLD_CODE_LSB = 0;
  localparam int COMPLETION_TIMER_BIT = 3;
  localparam int STMR_EN_BIT = 2;
  localparam int STMR_LSB = 0;
  localparam int PROF_BIT = 7;
  localparam int COOL_BIT = 6;
  localparam int ISO_OFF_BIT = 4;
  localparam int REG_EN_BIT = 3;
  localparam int EOC_BIT = 2;
  localparam int ADPT_BIT = 1;
  localparam int CHG_EN_BIT = 0;

  // Code decoding, voltages in mV or 10 mV, currents in mA or 0.1 mA
  localparam logic [15:0] FLOAT_VOLTAGE_CODE_BASE_MV = 16'h0DE8;
  localparam logic [15:0] FLOAT_VOLTAGE_CODE_STEP_MV = 16'h0014;
  localparam logic [5:0] FLOAT_VOLTAGE_CODE_CAP_CODE = 6'h37;
  localparam logic [15:0] TRK_TABLE [4] = '{16'h000A, 16'h0019, 16'h0032, 16'h0064};
  localparam logic [15:0] END_CURRENT_CODE_C1 = 16'h0032;
  localparam logic [15:0] END_CURRENT_CODE_C2 = 16'h004B;
  localparam logic [15:0] END_CURRENT_CODE_BASE = 16'h007D;
  localparam logic [15:0] END_CURRENT_CODE_STEP = 16'h0032;
  localparam logic [2:0] END_CURRENT_CODE_LIN_CODE = 3'h3;
  localparam logic [15:0] FAST_CURRENT_CODE_STEP_MA = 16'h000A;
  localparam logic [15:0] RECHARGE_OFFSET_CODE_STEP_MV = 16'h003C;
  localparam logic [15:0] VDEAD_TABLE [4] = '{16'h00C8, 16'h00FA, 16'h0104, 16'h0122};
  localparam logic [15:0] WEAK_BATTERY_THRESHOLD_CODE_BASE = 16'h010E;
  localparam logic [15:0] WEAK_BATTERY_THRESHOLD_CODE_STEP = 16'h000A;
  localparam logic [15:0] TRK_TMR_STEP_MIN = 16'h000F;
  localparam logic [15:0] FAST_TMR_STEP_MIN = 16'h0096;
  localparam logic [15:0] COOL_DIV_HALF = 16'h0002;
  localparam logic [15:0] COOL_DIV_TENTH = 16'h000A;

  // Timing
  localparam int CLK_HZ = 25000000;
  localparam int DEGLITCH_MS = 32;
  localparam int COMPLETION_MS = 1000;
  localparam int DG_CYCLES_DEF = DEGLITCH_MS * (CLK_HZ / 1000);
  localparam int END_CYCLES_DEF = COMPLETION_MS * (CLK_HZ / 1000);
  localparam int TMR_W = 26;
  localparam logic [1:0] STRAP_LOAD_CNT = 2'h2;

  typedef enum {EOC_IDLE, EOC_DEGLITCH, EOC_HOLDOFF, EOC_DONE} ccr_eoc_e;
endpackage

/* hw/ccr_field_reg.sv */
// One eight-bit configuration register with masked write and strap load
`timescale 1ns/10ps
`default_nettype none
module ccr_field_reg #(
  parameter logic [7:0] RST_VAL = 8'h00,
  parameter logic [7:0] WR_MASK = 8'hFF,
  parameter logic [7:0] STRAP_MASK = 8'h00
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic [7:0] wdata,
  input wire logic strap_load,
  input wire logic [7:0] strap_val,
  output logic [7:0] q
);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= RST_VAL;
    end else if (strap_load) begin
      q <= (q & ~STRAP_MASK) | (strap_val & STRAP_MASK);
    end else if (wr_en) begin
      // Any code is kept as written, reserved ones included
      q <= wdata & WR_MASK; // (R19)
    end
  end
endmodule
`default_nettype wire

/* hw/ccr_bank.sv */
// Charger configuration register bank with decoded settings and end-of-charge qualifier
`timescale 1ns/10ps
`default_nettype none
// Contract
// (R1) Float code steps 20 mV to 4.64 V; codes 110111 and above give 4.66 V.
// (R2) Trickle current code: 1, 2.5, 5, 10 mA; resets to 5 mA.
// (R3) End current code 001 5 mA, 010 7.5 mA, then 12.5 to 32.5 mA; default 001.
// (R4) Fast current 10 mA per step from 10 mA to 320 mA; default 100 mA.
// (R5) Recharge inhibit bit suppresses automatic recharge when set; resets clear.
// (R6) Recharge offset 120, 180, 240 mV; default code 01.
// (R7) Dead battery threshold 2.0, 2.5, 2.6, 2.9 V; default 2.5 V.
// (R8) Weak battery threshold 2.7 V to 3.4 V in 0.1 V steps; default 3.0 V.
// (R9) Completion timer off when bit clear; 32 ms deglitch still qualifies completion.
// (R10) Safety timer enable runs both trickle and fast timers; resets set.
// (R11) Timeout pair 15/150 up to 60/600 minutes; default 60/600.
// (R12) Temperature profile enable bit; resets clear.
// (R13) Cool zone current: half when clear, one tenth when set; resets clear.
// (R14) Force-off opens isolation switch; supply shuts only with battery present.
// (R15) Charge regulator enable bit; resets set.
// (R16) End of charge may be declared only while its permit bit is set.
// (R17) Adaptive input current limit enable bit; resets clear.
// (R18) Charging runs only with charge enable and regulator enable set; factory reset.
// (R19) Unlisted codes are stored as written and flagged as reserved.
module ccr_bank #(
  parameter int DG_CYCLES = ccr_pkg::DG_CYCLES_DEF,
  parameter int END_CYCLES = ccr_pkg::END_CYCLES_DEF
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA,
  output logic REG_RVALID,
  output logic REG_READY,
  input wire logic [5:0] FACTORY_FLOAT_CODE,
  input wire logic FACTORY_CHARGING_ENABLE,
  input wire logic EOC_DETECT,
  input wire logic BATTERY_PRESENT,
  output logic [15:0] FLOAT_VOLTAGE_MV,
  output logic [15:0] TRICKLE_CURRENT_DMA,
  output logic [15:0] END_CURRENT_DMA,
  output logic [15:0] FAST_CURRENT_MA,
  output logic [15:0] COOL_CURRENT_MA,
  output logic RECHARGE_ENABLE,
  output logic [15:0] RECHARGE_OFFSET_MV,
  output logic [15:0] DEAD_THRESHOLD_CV,
  output logic [15:0] WEAK_THRESHOLD_CV,
  output logic SAFETY_TIMER_RUN,
  output logic [15:0] TRICKLE_TIMEOUT_MIN,
  output logic [15:0] FAST_TIMEOUT_MIN,
  output logic PROFILE_ENABLE,
  output logic ISOLATION_SWITCH_ON,
  output logic SYSTEM_SUPPLY_OFF,
  output logic REGULATOR_ON,
  output logic ADAPTIVE_LIMIT_ON,
  output logic CHARGE_RUN,
  output logic CHARGE_DONE,
  output logic RESERVED_CODE
);
  logic [5:0] strap_code_meta, strap_code_sync;
  logic strap_en_meta, strap_en_sync;
  logic eoc_meta, eoc_sync, bat_meta, bat_sync;
  logic [1:0] load_cnt_reg;
  logic loaded_reg;
  logic strap_load;
  logic wr_ok;
  logic [7:0] term_q, curr_q, thrs_q, timer_q, func_q;
  logic [5:0] float_voltage_code;
  logic [1:0] trickle_current_code, recharge_offset_code, dead_battery_threshold_code, safety_timer_period;
  logic [2:0] end_current_code, weak_battery_threshold_code;
  logic [4:0] fast_current_code;
  logic recharge_inhibit, completion_timer_enable, safety_timer_enable;
  logic temperature_profile_enable, cool_zone_current_select, isolation_switch_force_off;
  logic charge_regulator_enable, eoc_allow, adaptive_enable, charging_enable;
  logic [15:0] fast_ma;
  logic [5:0] vcode_capped;
  ccr_pkg::ccr_eoc_e eoc_state_reg;
  logic [ccr_pkg::TMR_W-1:0] eoc_cnt_reg;
  logic eoc_qual;

  // Synchronisers for pins
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      strap_code_meta <= 6'h00;
      strap_code_sync <= 6'h00;
      strap_en_meta <= 1'b0;
      strap_en_sync <= 1'b0;
      eoc_meta <= 1'b0;
      eoc_sync <= 1'b0;
      bat_meta <= 1'b0;
      bat_sync <= 1'b0;
    end else begin
      strap_code_meta <= FACTORY_FLOAT_CODE;
      strap_code_sync <= strap_code_meta;
      strap_en_meta <= FACTORY_CHARGING_ENABLE;
      strap_en_sync <= strap_en_meta;
      eoc_meta <= EOC_DETECT;
      eoc_sync <= eoc_meta;
      bat_meta <= BATTERY_PRESENT;
      bat_sync <= bat_meta;
    end
  end

  // Factory values are loaded once the strap synchronisers have settled
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      load_cnt_reg <= 2'h0;
      loaded_reg <= 1'b0;
    end else if (!loaded_reg) begin
      load_cnt_reg <= load_cnt_reg + 2'h1;
      if (load_cnt_reg == ccr_pkg::STRAP_LOAD_CNT) begin
        loaded_reg <= 1'b1;
      end
    end
  end
  assign strap_load = !loaded_reg && (load_cnt_reg == ccr_pkg::STRAP_LOAD_CNT);
  assign wr_ok = REG_WR && loaded_reg;

  ccr_field_reg #(.RST_VAL(ccr_pkg::TERM_RST), .WR_MASK(ccr_pkg::ALL_MASK), .STRAP_MASK(ccr_pkg::TERM_STRAP_MASK))
  u_term (.clk(CLK), .rst_n(RST_N), .wr_en(wr_ok && REG_ADDR == ccr_pkg::OFS_TERM), .wdata(REG_WDATA),
    .strap_load(strap_load), .strap_val({strap_code_sync, 2'h0}), .q(term_q));
  ccr_field_reg #(.RST_VAL(ccr_pkg::CURR_RST), .WR_MASK(ccr_pkg::ALL_MASK), .STRAP_MASK(ccr_pkg::NONE_MASK))
  u_curr (.clk(CLK), .rst_n(RST_N), .wr_en(wr_ok && REG_ADDR == ccr_pkg::OFS_CURR), .wdata(REG_WDATA),
    .strap_load(1'b0), .strap_val(8'h00), .q(curr_q));
  ccr_field_reg #(.RST_VAL(ccr_pkg::THRS_RST), .WR_MASK(ccr_pkg::ALL_MASK), .STRAP_MASK(ccr_pkg::NONE_MASK))
  u_thrs (.clk(CLK), .rst_n(RST_N), .wr_en(wr_ok && REG_ADDR == ccr_pkg::OFS_THRS), .wdata(REG_WDATA),
    .strap_load(1'b0), .strap_val(8'h00), .q(thrs_q));
  ccr_field_reg #(.RST_VAL(ccr_pkg::TIMER_RST), .WR_MASK(ccr_pkg::TIMER_MASK), .STRAP_MASK(ccr_pkg::NONE_MASK))
  u_timer (.clk(CLK), .rst_n(RST_N), .wr_en(wr_ok && REG_ADDR == ccr_pkg::OFS_TIMER), .wdata(REG_WDATA),
    .strap_load(1'b0), .strap_val(8'h00), .q(timer_q));
  ccr_field_reg #(.RST_VAL(ccr_pkg::FUNC_RST), .WR_MASK(ccr_pkg::ALL_MASK), .STRAP_MASK(ccr_pkg::FUNC_STRAP_MASK))
  u_func (.clk(CLK), .rst_n(RST_N), .wr_en(wr_ok && REG_ADDR == ccr_pkg::OFS_FUNC), .wdata(REG_WDATA),
    .strap_load(strap_load), .strap_val({7'h00, strap_en_sync}), .q(func_q));

  assign float_voltage_code = term_q[ccr_pkg::FLOAT_VOLTAGE_CODE_LSB +: 6];
  assign trickle_current_code = term_q[ccr_pkg::TRK_LSB +: 2];
  assign end_current_code = curr_q[ccr_pkg::END_CURRENT_CODE_LSB +: 3];
  assign fast_current_code = curr_q[ccr_pkg::FAST_CURRENT_CODE_LSB +: 5];
  assign recharge_inhibit = thrs_q[ccr_pkg::RCH_INH_BIT];
  assign recharge_offset_code = thrs_q[ccr_pkg::RECHARGE_OFFSET_CODE_LSB +: 2];
  assign dead_battery_threshold_code = thrs_q[ccr_pkg::VDEAD_LSB +: 2];
  assign weak_battery_threshold_code = thrs_q[ccr_pkg::WEAK_BATTERY_THRESHOLD_CODE_LSB +: 3];
  assign completion_timer_enable = timer_q[ccr_pkg::COMPLETION_TIMER_BIT];
  assign safety_timer_enable = timer_q[ccr_pkg::STMR_EN_BIT];
  assign safety_timer_period = timer_q[ccr_pkg::STMR_LSB +: 2];
  assign temperature_profile_enable = func_q[ccr_pkg::PROF_BIT];
  assign cool_zone_current_select = func_q[ccr_pkg::COOL_BIT];
  assign isolation_switch_force_off = func_q[ccr_pkg::ISO_OFF_BIT];
  assign charge_regulator_enable = func_q[ccr_pkg::REG_EN_BIT];
  assign eoc_allow = func_q[ccr_pkg::EOC_BIT];
  assign adaptive_enable = func_q[ccr_pkg::ADPT_BIT];
  assign charging_enable = func_q[ccr_pkg::CHG_EN_BIT];

  assign vcode_capped = (float_voltage_code > ccr_pkg::FLOAT_VOLTAGE_CODE_CAP_CODE) ? ccr_pkg::FLOAT_VOLTAGE_CODE_CAP_CODE : float_voltage_code; // (R1)
  assign fast_ma = 16'(({11'h000, fast_current_code} + 16'h0001) * ccr_pkg::FAST_CURRENT_CODE_STEP_MA); // (R4)

  // Register read port, unmapped offsets read zero
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      REG_RDATA <= 8'h00;
      REG_RVALID <= 1'b0;
      REG_READY <= 1'b0;
    end else begin
      REG_RVALID <= REG_RD;
      REG_READY <= loaded_reg;
      if (REG_RD) begin
        case (REG_ADDR)
          ccr_pkg::OFS_TERM: REG_RDATA <= term_q;
          ccr_pkg::OFS_CURR: REG_RDATA <= curr_q;
          ccr_pkg::OFS_THRS: REG_RDATA <= thrs_q;
          ccr_pkg::OFS_TIMER: REG_RDATA <= timer_q;
          ccr_pkg::OFS_FUNC: REG_RDATA <= func_q;
          default: REG_RDATA <= 8'h00;
        endcase
      end
    end
  end

  // Decoded analog settings
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      FLOAT_VOLTAGE_MV <= 16'h0000;
      TRICKLE_CURRENT_DMA <= 16'h0000;
      END_CURRENT_DMA <= 16'h0000;
      FAST_CURRENT_MA <= 16'h0000;
      COOL_CURRENT_MA <= 16'h0000;
      RECHARGE_OFFSET_MV <= 16'h0000;
      DEAD_THRESHOLD_CV <= 16'h0000;
      WEAK_THRESHOLD_CV <= 16'h0000;
      RESERVED_CODE <= 1'b0;
    end else begin
      FLOAT_VOLTAGE_MV <= 16'(ccr_pkg::FLOAT_VOLTAGE_CODE_BASE_MV + {10'h000, vcode_capped} * ccr_pkg::FLOAT_VOLTAGE_CODE_STEP_MV); // (R1)
      TRICKLE_CURRENT_DMA <= ccr_pkg::TRK_TABLE[trickle_current_code]; // (R2)
      case (end_current_code)
        3'h0: END_CURRENT_DMA <= 16'h0000;
        3'h1: END_CURRENT_DMA <= ccr_pkg::END_CURRENT_CODE_C1; // (R3)
        3'h2: END_CURRENT_DMA <= ccr_pkg::END_CURRENT_CODE_C2; // (R3)
        default: END_CURRENT_DMA <= 16'(ccr_pkg::END_CURRENT_CODE_BASE
          + {13'h0000, 3'(end_current_code - ccr_pkg::END_CURRENT_CODE_LIN_CODE)} * ccr_pkg::END_CURRENT_CODE_STEP); // (R3)
      endcase
      FAST_CURRENT_MA <= fast_ma; // (R4)
      if (!temperature_profile_enable) begin
        COOL_CURRENT_MA <= fast_ma; // (R12)
      end else if (cool_zone_current_select) begin
        COOL_CURRENT_MA <= fast_ma / ccr_pkg::COOL_DIV_TENTH; // (R13)
      end else begin
        COOL_CURRENT_MA <= fast_ma / ccr_pkg::COOL_DIV_HALF; // (R13)
      end
      RECHARGE_OFFSET_MV <= 16'(({14'h0000, recharge_offset_code} + 16'h0001) * ccr_pkg::RECHARGE_OFFSET_CODE_STEP_MV); // (R6)
      if (recharge_offset_code == 2'h0) begin
        RECHARGE_OFFSET_MV <= 16'h0000; // (R19)
      end
      DEAD_THRESHOLD_CV <= ccr_pkg::VDEAD_TABLE[dead_battery_threshold_code]; // (R7)
      WEAK_THRESHOLD_CV <= 16'(ccr_pkg::WEAK_BATTERY_THRESHOLD_CODE_BASE + {13'h0000, weak_battery_threshold_code} * ccr_pkg::WEAK_BATTERY_THRESHOLD_CODE_STEP); // (R8)
      RESERVED_CODE <= (end_current_code == 3'h0) || (recharge_offset_code == 2'h0); // (R19)
    end
  end

  // Control outputs
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      RECHARGE_ENABLE <= 1'b0;
      SAFETY_TIMER_RUN <= 1'b0;
      TRICKLE_TIMEOUT_MIN <= 16'h0000;
      FAST_TIMEOUT_MIN <= 16'h0000;
      PROFILE_ENABLE <= 1'b0;
      ISOLATION_SWITCH_ON <= 1'b0;
      SYSTEM_SUPPLY_OFF <= 1'b0;
      REGULATOR_ON <= 1'b0;
      ADAPTIVE_LIMIT_ON <= 1'b0;
      CHARGE_RUN <= 1'b0;
    end else begin
      RECHARGE_ENABLE <= !recharge_inhibit; // (R5)
      SAFETY_TIMER_RUN <= safety_timer_enable && CHARGE_RUN; // (R10)
      TRICKLE_TIMEOUT_MIN <= 16'(({14'h0000, safety_timer_period} + 16'h0001) * ccr_pkg::TRK_TMR_STEP_MIN); // (R11)
      FAST_TIMEOUT_MIN <= 16'(({14'h0000, safety_timer_period} + 16'h0001) * ccr_pkg::FAST_TMR_STEP_MIN); // (R11)
      PROFILE_ENABLE <= temperature_profile_enable; // (R12)
      ISOLATION_SWITCH_ON <= !isolation_switch_force_off; // (R14)
      SYSTEM_SUPPLY_OFF <= isolation_switch_force_off && bat_sync; // (R14)
      REGULATOR_ON <= charge_regulator_enable; // (R15)
      ADAPTIVE_LIMIT_ON <= adaptive_enable && CHARGE_RUN; // (R17)
      CHARGE_RUN <= charging_enable && charge_regulator_enable && loaded_reg; // (R18)
    end
  end

  // End-of-charge qualifier: deglitch, then optional completion hold-off
  assign eoc_qual = eoc_sync && eoc_allow && CHARGE_RUN; // (R16)
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      eoc_state_reg <= ccr_pkg::EOC_IDLE;
      eoc_cnt_reg <= '0;
      CHARGE_DONE <= 1'b0;
    end else if (!eoc_qual) begin
      eoc_state_reg <= ccr_pkg::EOC_IDLE;
      eoc_cnt_reg <= '0;
      CHARGE_DONE <= 1'b0;
    end else begin
      case (eoc_state_reg)
        ccr_pkg::EOC_IDLE: begin
          eoc_state_reg <= ccr_pkg::EOC_DEGLITCH;
          eoc_cnt_reg <= '0;
        end
        ccr_pkg::EOC_DEGLITCH: begin
          eoc_cnt_reg <= eoc_cnt_reg + 1'b1;
          if (eoc_cnt_reg == ccr_pkg::TMR_W'(DG_CYCLES - 1)) begin
            eoc_cnt_reg <= '0;
            if (completion_timer_enable) begin
              eoc_state_reg <= ccr_pkg::EOC_HOLDOFF;
            end else begin
              eoc_state_reg <= ccr_pkg::EOC_DONE; // (R9)
              CHARGE_DONE <= 1'b1;
            end
          end
        end
        ccr_pkg::EOC_HOLDOFF: begin
          eoc_cnt_reg <= eoc_cnt_reg + 1'b1;
          if (eoc_cnt_reg == ccr_pkg::TMR_W'(END_CYCLES - 1)) begin
            eoc_state_reg <= ccr_pkg::EOC_DONE;
            CHARGE_DONE <= 1'b1;
          end
        end
        ccr_pkg::EOC_DONE: CHARGE_DONE <= 1'b1;
        default: eoc_state_reg <= ccr_pkg::EOC_IDLE;
      endcase
    end
  end

  // Checks
  charge_gate_a: assert property (@(posedge CLK) disable iff (!RST_N) // (R18)
    CHARGE_RUN |-> $past(charging_enable) && $past(charge_regulator_enable)) else $error("charge ran ungated");
  iso_supply_a: assert property (@(posedge CLK) disable iff (!RST_N) // (R14)
    SYSTEM_SUPPLY_OFF |-> !ISOLATION_SWITCH_ON || $past(isolation_switch_force_off) != isolation_switch_force_off)
    else $error("supply off with switch on");
  float_cap_a: assert property (@(posedge CLK) disable iff (!RST_N) // (R1)
    $past(float_voltage_code) >= ccr_pkg::FLOAT_VOLTAGE_CODE_CAP_CODE |-> FLOAT_VOLTAGE_MV == 16'h1234)
    else $error("float voltage not capped");
  fast_curr_a: assert property (@(posedge CLK) disable iff (!RST_N) // (R4)
    $past(fast_current_code) == 5'h1F |-> FAST_CURRENT_MA == 16'h0140) else $error("fast current top wrong");
  timer_pair_a: assert property (@(posedge CLK) disable iff (!RST_N) // (R11)
    FAST_TIMEOUT_MIN == 16'(TRICKLE_TIMEOUT_MIN * 16'h000A)) else $error("timeout pair mismatch");
  done_needs_eoc_a: assert property (@(posedge CLK) disable iff (!RST_N) // (R16)
    $rose(CHARGE_DONE) |-> $past(eoc_allow) && $past(eoc_state_reg) != ccr_pkg::EOC_IDLE)
    else $error("done without permit");
  deglitch_a: assert property (@(posedge CLK) disable iff (!RST_N) // (R9)
    $rose(CHARGE_DONE) && $past(eoc_state_reg) == ccr_pkg::EOC_DEGLITCH
    |-> $past(eoc_cnt_reg) == ccr_pkg::TMR_W'(DG_CYCLES - 1) && !$past(completion_timer_enable))
    else $error("deglitch length wrong");
  read_back_a: assert property (@(posedge CLK) disable iff (!RST_N) // (R19)
    wr_ok && REG_ADDR == ccr_pkg::OFS_CURR ##1 REG_RD && REG_ADDR == ccr_pkg::OFS_CURR && !REG_WR
    |=> REG_RVALID && REG_RDATA == $past(REG_WDATA, 2)) else $error("readback differs");
  reserved_a: assert property (@(posedge CLK) disable iff (!RST_N) // (R19)
    $past(end_current_code) == 3'h0 |-> RESERVED_CODE && END_CURRENT_DMA == 16'h0000)
    else $error("reserved code not flagged");
  cover_done: cover property (@(posedge CLK) disable iff (!RST_N) $rose(CHARGE_DONE));
  cover_run: cover property (@(posedge CLK) disable iff (!RST_N) $rose(CHARGE_RUN));
  cover_iso: cover property (@(posedge CLK) disable iff (!RST_N) $rose(SYSTEM_SUPPLY_OFF));
  cover_cool: cover property (@(posedge CLK) disable iff (!RST_N) PROFILE_ENABLE && COOL_CURRENT_MA != FAST_CURRENT_MA);
endmodule
`default_nettype wire

/* test/ccr_bank_tb.sv */
// Self-checking testbench for the charger configuration register bank
`timescale 1ns/10ps
`default_nettype none
module ccr_bank_tb;
  localparam int DG = 20;
  localparam int ENDC = 30;
  logic CLK, RST_N, REG_WR, REG_RD, FACTORY_CHARGING_ENABLE, EOC_DETECT, BATTERY_PRESENT;
  logic [7:0] REG_ADDR, REG_WDATA, REG_RDATA;
  logic [5:0] FACTORY_FLOAT_CODE;
  logic REG_RVALID, REG_READY, RECHARGE_ENABLE, SAFETY_TIMER_RUN, PROFILE_ENABLE, ISOLATION_SWITCH_ON;
  logic SYSTEM_SUPPLY_OFF, REGULATOR_ON, ADAPTIVE_LIMIT_ON, CHARGE_RUN, CHARGE_DONE, RESERVED_CODE;
  logic [15:0] FLOAT_VOLTAGE_MV, TRICKLE_CURRENT_DMA, END_CURRENT_DMA, FAST_CURRENT_MA, COOL_CURRENT_MA;
  logic [15:0] RECHARGE_OFFSET_MV, DEAD_THRESHOLD_CV, WEAK_THRESHOLD_CV, TRICKLE_TIMEOUT_MIN, FAST_TIMEOUT_MIN;
  int error_cnt;
  int cmp_count;
  ccr_bank #(.DG_CYCLES(DG), .END_CYCLES(ENDC)) u_dut (
    .CLK(CLK), .RST_N(RST_N), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
    .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID), .REG_READY(REG_READY),
    .FACTORY_FLOAT_CODE(FACTORY_FLOAT_CODE), .FACTORY_CHARGING_ENABLE(FACTORY_CHARGING_ENABLE),
    .EOC_DETECT(EOC_DETECT), .BATTERY_PRESENT(BATTERY_PRESENT), .FLOAT_VOLTAGE_MV(FLOAT_VOLTAGE_MV),
    .TRICKLE_CURRENT_DMA(TRICKLE_CURRENT_DMA), .END_CURRENT_DMA(END_CURRENT_DMA),
    .FAST_CURRENT_MA(FAST_CURRENT_MA), .COOL_CURRENT_MA(COOL_CURRENT_MA), .RECHARGE_ENABLE(RECHARGE_ENABLE),
    .RECHARGE_OFFSET_MV(RECHARGE_OFFSET_MV), .DEAD_THRESHOLD_CV(DEAD_THRESHOLD_CV),
    .WEAK_THRESHOLD_CV(WEAK_THRESHOLD_CV), .SAFETY_TIMER_RUN(SAFETY_TIMER_RUN),
    .TRICKLE_TIMEOUT_MIN(TRICKLE_TIMEOUT_MIN), .FAST_TIMEOUT_MIN(FAST_TIMEOUT_MIN),
    .PROFILE_ENABLE(PROFILE_ENABLE), .ISOLATION_SWITCH_ON(ISOLATION_SWITCH_ON),
    .SYSTEM_SUPPLY_OFF(SYSTEM_SUPPLY_OFF), .REGULATOR_ON(REGULATOR_ON), .ADAPTIVE_LIMIT_ON(ADAPTIVE_LIMIT_ON),
    .CHARGE_RUN(CHARGE_RUN), .CHARGE_DONE(CHARGE_DONE), .RESERVED_CODE(RESERVED_CODE)
  );
  initial begin
    CLK = 1'b0;
    forever #20 CLK = ~CLK;
  end
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge CLK) begin
      REG_WR <= 1'b1;
      REG_ADDR <= a;
      REG_WDATA <= d;
    end
    @(posedge CLK) REG_WR <= 1'b0;
    @(posedge CLK) #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge CLK) begin
      REG_RD <= 1'b1;
      REG_ADDR <= a;
    end
    @(posedge CLK) REG_RD <= 1'b0;
    #1 chk({15'h0, REG_RVALID}, 16'h1);
    chk({8'h0, REG_RDATA}, {8'h0, e});
  endtask
  task automatic t_reset();
    rd(8'h03, 8'hAA);
    rd(8'h04, 8'h29);
    rd(8'h05, 8'h2B);
    rd(8'h06, 8'h07);
    rd(8'h07, 8'h0D);
    chk(FLOAT_VOLTAGE_MV, 16'd4400);
    chk(TRICKLE_CURRENT_DMA, 16'd50);
    chk(END_CURRENT_DMA, 16'd50);
    chk(FAST_CURRENT_MA, 16'd100);
    chk({RECHARGE_ENABLE, PROFILE_ENABLE, ISOLATION_SWITCH_ON, REGULATOR_ON, 12'h0}, 16'hB000);
    chk({CHARGE_RUN, SAFETY_TIMER_RUN, ADAPTIVE_LIMIT_ON, RESERVED_CODE, 12'h0}, 16'hC000);
    chk(RECHARGE_OFFSET_MV, 16'd120);
    chk(DEAD_THRESHOLD_CV, 16'd250);
    chk(WEAK_THRESHOLD_CV, 16'd300);
    chk(FAST_TIMEOUT_MIN, 16'd600);
    wr(8'h08, 8'hFF);
    rd(8'h08, 8'h00);
  endtask
  task automatic t_term();
    logic [15:0] trk [4];
    trk = '{16'd10, 16'd25, 16'd50, 16'd100};
    for (int c = 47; c < 64; c++) begin
      wr(8'h03, {c[5:0], c[1:0]});
      chk(FLOAT_VOLTAGE_MV, 16'(3560 + 20 * (c > 55 ? 55 : c)));
      chk(TRICKLE_CURRENT_DMA, trk[c % 4]);
    end
  endtask
  task automatic t_curr();
    for (int e = 0; e < 8; e++) begin
      wr(8'h04, {e[2:0], 5'(31 - 4 * e)});
      rd(8'h04, {e[2:0], 5'(31 - 4 * e)});
      chk(END_CURRENT_DMA, 16'(e == 0 ? 0 : e == 1 ? 50 : e == 2 ? 75 : 125 + 50 * (e - 3)));
      chk(FAST_CURRENT_MA, 16'(10 * (32 - 4 * e)));
      chk({15'h0, RESERVED_CODE}, {15'h0, e == 0});
    end
    // Back-to-back write then read of the same register
    @(posedge CLK) begin
      REG_WR <= 1'b1;
      REG_ADDR <= 8'h04;
      REG_WDATA <= 8'h29;
    end
    @(posedge CLK) begin
      REG_WR <= 1'b0;
      REG_RD <= 1'b1;
    end
    @(posedge CLK) REG_RD <= 1'b0;
    #1 chk({7'h0, REG_RVALID, REG_RDATA}, 16'h0129);
  endtask
  task automatic t_thrs();
    logic [15:0] ofs [4];
    logic [15:0] dead [4];
    ofs = '{16'd0, 16'd120, 16'd180, 16'd240};
    dead = '{16'd200, 16'd250, 16'd260, 16'd290};
    for (int i = 0; i < 8; i++) begin
      wr(8'h05, {i[0], i[1:0], i[1:0], i[2:0]});
      chk({15'h0, RECHARGE_ENABLE}, {15'h0, !i[0]});
      chk(RECHARGE_OFFSET_MV, ofs[i % 4]);
      chk({15'h0, RESERVED_CODE}, {15'h0, i % 4 == 0});
      chk(DEAD_THRESHOLD_CV, dead[i % 4]);
      chk(WEAK_THRESHOLD_CV, 16'(270 + 10 * i));
    end
  endtask
  task automatic t_timer();
    for (int p = 0; p < 4; p++) begin
      wr(8'h06, {5'h1E, p[0], p[1:0]});
      rd(8'h06, {5'h00, p[0], p[1:0]});
      chk(TRICKLE_TIMEOUT_MIN, 16'(15 * (p + 1)));
      chk(FAST_TIMEOUT_MIN, 16'(150 * (p + 1)));
      chk({15'h0, SAFETY_TIMER_RUN}, {15'h0, p[0]});
    end
  endtask
  task automatic t_func();
    logic [7:0] fv [6];
    logic run;
    fv = '{8'h8D, 8'hCD, 8'h3F, 8'h1D, 8'h05, 8'h0A};
    for (int i = 0; i < 6; i++) begin
      @(posedge CLK) BATTERY_PRESENT <= i[0];
      wr(8'h07, fv[i]);
      repeat (3) @(posedge CLK);
      #1 rd(8'h07, fv[i]);
      run = fv[i][0] & fv[i][3];
      chk({15'h0, PROFILE_ENABLE}, {15'h0, fv[i][7]});
      chk(COOL_CURRENT_MA, fv[i][7] ? (fv[i][6] ? 16'd10 : 16'd50) : 16'd100);
      chk({ISOLATION_SWITCH_ON, SYSTEM_SUPPLY_OFF}, {!fv[i][4], fv[i][4] & i[0]});
      chk({REGULATOR_ON, CHARGE_RUN}, {fv[i][3], run});
      chk({ADAPTIVE_LIMIT_ON, SAFETY_TIMER_RUN}, {fv[i][1] & run, run});
    end
  endtask
  task automatic t_eoc(input logic tm);
    int n;
    n = 0;
    wr(8'h06, tm ? 8'h0F : 8'h07);
    wr(8'h07, 8'h0D);
    @(posedge CLK) EOC_DETECT <= 1'b1;
    repeat (DG / 2) @(posedge CLK);
    EOC_DETECT <= 1'b0;
    repeat (4) @(posedge CLK);
    EOC_DETECT <= 1'b1;
    while (CHARGE_DONE !== 1'b1 && n < 200) begin
      @(posedge CLK) #1;
      n++;
    end
    chk({15'h0, n >= DG + 1 + (tm ? ENDC : 0) && n <= DG + 5 + (tm ? ENDC : 0)}, 16'h1);
    @(posedge CLK) EOC_DETECT <= 1'b0;
    repeat (4) @(posedge CLK);
    #1 chk({15'h0, CHARGE_DONE}, 16'h0);
    wr(8'h07, 8'h09);
    @(posedge CLK) EOC_DETECT <= 1'b1;
    repeat (DG + ENDC + 10) @(posedge CLK);
    #1 chk({15'h0, CHARGE_DONE}, 16'h0);
    @(posedge CLK) EOC_DETECT <= 1'b0;
  endtask
  task automatic end_sim();
    $display("Mismatches %0d of %0d comparisons", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    #400000;
    error_cnt++;
    end_sim();
  end
  initial begin
    error_cnt = 0;
    cmp_count = 0;
    RST_N = 1'b0;
    {REG_WR, REG_RD, EOC_DETECT, BATTERY_PRESENT} = 4'h0;
    {REG_ADDR, REG_WDATA} = 16'h0;
    FACTORY_FLOAT_CODE = 6'h2A;
    FACTORY_CHARGING_ENABLE = 1'b1;
    repeat (6) @(posedge CLK);
    RST_N <= 1'b1;
    // Early write lands before straps are loaded and must be dropped
    wr(8'h04, 8'h00);
    for (int i = 0; i < 20 && REG_READY !== 1'b1; i++) @(posedge CLK);
    t_reset();
    t_term();
    t_curr();
    t_thrs();
    t_timer();
    t_func();
    t_eoc(1'b0);
    t_eoc(1'b1);
    end_sim();
  end
endmodule
`default_nettype wire
